// File: logic/amr_pkg.sv
// Purpose: Shared constants and types for the alarm monitor and reset block
// Assumes: Results arrive as one-cycle strobes per channel, 12-bit codes
// Notes:   Temperatures are unsigned whole degrees in the low bits of a result
package amr_pkg;
  localparam int NUM_IN    = 4;
  localparam int NUM_TEMP  = 3;
  localparam int NUM_CH    = 7;
  localparam int RES_W     = 12;
  localparam int CNT_W     = 9;
  localparam int NUM_ALM   = 11;
  localparam logic [2:0]  IN_SEL_RST   = 3'h3;
  localparam logic [1:0]  TEMP_SEL_RST = 2'h2;
  localparam logic [11:0] OVERTEMP_LIM = 12'h096;
  localparam logic [11:0] OVERTEMP_HYS = 12'h008;
  localparam logic [15:0] SPI_RST_KEY  = 16'h6600;
  localparam int SW_RST_US = 30;
  localparam int CLK_MHZ   = 20;
  localparam int SW_RST_CYC = SW_RST_US * CLK_MHZ;

  typedef struct packed {
    logic [RES_W-1:0] high;
    logic [RES_W-1:0] low;
    logic [6:0]       hys;
  } amr_limit_type;

  typedef enum logic {AMR_RUN, AMR_SWRST} amr_state_type;
endpackage

// File: logic/amr_channel.sv
// Purpose: One channel window check with hysteresis and debounce count
// Assumes: Limits are stable while a result strobe is present
// Notes:   Count saturates at 1FFh, above the largest selectable N (256)
`timescale 1ns/10ps
module amr_channel (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clr,
  input  wire logic                  valid,
  input  wire logic [11:0]           result,
  input  wire amr_pkg::amr_limit_type lim,
  input  wire logic [8:0]            need,
  input  wire logic                  sticky,
  input  wire logic                  read_clr,
  output logic                       flag
);
  logic [8:0] cnt_reg, cnt_next;
  logic       cond_reg, cond_next;
  logic       flag_next;
  logic       outside, back_in;

  // Window test and hysteresis release
  always_comb begin
    outside = (result > lim.high) || (result < lim.low);
    back_in = ({1'b0, result} + {6'h00, lim.hys} <= {1'b0, lim.high}) &&
              ({1'b0, result} >= {1'b0, lim.low} + {6'h00, lim.hys});
    cnt_next  = cnt_reg;
    cond_next = cond_reg;
    if (valid) begin
      if (!outside) begin
        cnt_next = 9'h000;
      end else if (cnt_reg != 9'h1FF) begin
        cnt_next = cnt_reg + 9'h001;
      end
      if (outside && (cnt_reg + 9'h001 >= need)) begin
        cond_next = 1'b1;
      end else if (cond_reg && back_in) begin
        cond_next = 1'b0;
      end
    end
    if (clr) begin
      cnt_next  = 9'h000;
      cond_next = 1'b0;
    end
    // Sticky: set wins over read clear, resets arrive on read_clr too
    if (sticky) begin
      flag_next = cond_next || (flag && !read_clr);
    end else begin
      flag_next = cond_next;
    end
  end

  // State registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 9'h000;
      cond_reg <= 1'b0;
      flag     <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      cond_reg <= cond_next;
      flag     <= flag_next;
    end
  end
endmodule

// File: logic/amr_top.sv
// Purpose: Alarm supervision, open-drain alarm pin and reset handling
// Assumes: Config inputs come from the register file on this clock
// Notes:   Status bits: 0..3 inputs, 4..9 temp high/low pairs, 10 overtemp
`timescale 1ns/10ps
module amr_top (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        reset_n_pin,
  input  wire logic [6:0]                  result_valid,
  input  wire logic [6:0][11:0]            result,
  input  wire logic [11:0]                 die_temp,
  input  wire logic                        die_temp_valid,
  input  wire amr_pkg::amr_limit_type [6:0] limits,
  input  wire logic [2:0]                  input_debounce_count_sel,
  input  wire logic                        input_sel_wr,
  input  wire logic [1:0]                  temp_debounce_count_sel,
  input  wire logic                        temp_sel_wr,
  input  wire logic [10:0]                 source_irq_mask_bit,
  input  wire logic                        sticky_mode_off,
  input  wire logic                        status_read,
  input  wire logic                        sw_reset_wr,
  input  wire logic                        sw_reset_spi,
  input  wire logic [15:0]                 sw_reset_data,
  output logic [10:0]                      status_reg,
  output logic                             global_fault_flag,
  output logic                             die_overtemp_flag,
  output logic                             alarm_out,
  output logic                             alarm_oe,
  output logic                             defaults_reg,
  output logic                             host_busy_reg,
  output logic [2:0]                       in_sel_reg,
  output logic [1:0]                       temp_sel_reg
);
  logic                 rpin_s1_reg, rpin_s2_reg;
  amr_pkg::amr_state_type state_reg, state_next;
  logic [9:0]           tmr_reg, tmr_next;
  logic [2:0]           in_sel_next;
  logic [1:0]           temp_sel_next;
  logic                 clr_all, sw_hit, sel_clr_in, sel_clr_t;
  logic                 stat_clr;
  logic [8:0]           need_in, need_t;
  logic [10:0]          flags, enabled;
  logic [11:0]          t_hi_res [3], t_lo_res [3];
  amr_pkg::amr_limit_type t_hi_lim [3], t_lo_lim [3];
  amr_pkg::amr_limit_type ot_lim;
  logic                 alarm_next;

  // Reset pin synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rpin_s1_reg <= 1'b0;
      rpin_s2_reg <= 1'b0;
    end else begin
      rpin_s1_reg <= reset_n_pin;
      rpin_s2_reg <= rpin_s1_reg;
    end
  end

  // Software reset decode and host blocking window
  always_comb begin
    sw_hit     = sw_reset_wr && (!sw_reset_spi || sw_reset_data == amr_pkg::SPI_RST_KEY);
    state_next = state_reg;
    tmr_next   = tmr_reg;
    case (state_reg)
      amr_pkg::AMR_RUN: begin
        if (sw_hit) begin
          state_next = amr_pkg::AMR_SWRST;
          tmr_next   = 10'(amr_pkg::SW_RST_CYC - 1);
        end
      end
      amr_pkg::AMR_SWRST: begin
        if (tmr_reg == 10'h000) begin
          state_next = amr_pkg::AMR_RUN;
        end else begin
          tmr_next = tmr_reg - 10'h001;
        end
      end
      default: state_next = amr_pkg::AMR_RUN;
    endcase
    clr_all = !rpin_s2_reg || sw_hit || (state_reg == amr_pkg::AMR_SWRST);
    // In sticky mode status bits drop only on a read or a reset, never on a select write
    stat_clr = status_read || clr_all;
  end

  // Count select fields and their defaults
  always_comb begin
    in_sel_next   = in_sel_reg;
    temp_sel_next = temp_sel_reg;
    if (clr_all) begin
      in_sel_next   = amr_pkg::IN_SEL_RST;
      temp_sel_next = amr_pkg::TEMP_SEL_RST;
    end else begin
      if (input_sel_wr) in_sel_next = input_debounce_count_sel;
      if (temp_sel_wr) temp_sel_next = temp_debounce_count_sel;
    end
    sel_clr_in = clr_all || input_sel_wr;
    sel_clr_t  = clr_all || temp_sel_wr;
    need_in = (in_sel_reg == 3'h0) ? 9'h001 : 9'(9'h002 << in_sel_reg);
    need_t  = 9'(9'h001 << temp_sel_reg);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg     <= amr_pkg::AMR_RUN;
      tmr_reg       <= 10'h000;
      in_sel_reg    <= amr_pkg::IN_SEL_RST;
      temp_sel_reg  <= amr_pkg::TEMP_SEL_RST;
      defaults_reg  <= 1'b1;
      host_busy_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      tmr_reg       <= tmr_next;
      in_sel_reg    <= in_sel_next;
      temp_sel_reg  <= temp_sel_next;
      defaults_reg  <= clr_all;
      host_busy_reg <= (state_next == amr_pkg::AMR_SWRST);
    end
  end

  // Analog input channels
  genvar gi;
  generate
    for (gi = 0; gi < amr_pkg::NUM_IN; gi++) begin : g_in
      amr_channel u_ch (
        .clock(clock), .rst(rst), .clr(sel_clr_in), .valid(result_valid[gi]),
        .result(result[gi]), .lim(limits[gi]), .need(need_in),
        .sticky(!sticky_mode_off), .read_clr(stat_clr), .flag(flags[gi])
      );
    end
    // Temperature channels: separate high and low limit monitors
    for (gi = 0; gi < amr_pkg::NUM_TEMP; gi++) begin : g_t
      always_comb begin
        t_hi_res[gi] = result[amr_pkg::NUM_IN+gi];
        t_lo_res[gi] = result[amr_pkg::NUM_IN+gi];
        t_hi_lim[gi] = '{high: limits[amr_pkg::NUM_IN+gi].high, low: 12'h000,
                         hys: {2'h0, limits[amr_pkg::NUM_IN+gi].hys[4:0]}};
        t_lo_lim[gi] = '{high: 12'hFFF, low: limits[amr_pkg::NUM_IN+gi].low,
                         hys: {2'h0, limits[amr_pkg::NUM_IN+gi].hys[4:0]}};
      end
      amr_channel u_hi (
        .clock(clock), .rst(rst), .clr(sel_clr_t), .valid(result_valid[amr_pkg::NUM_IN+gi]),
        .result(t_hi_res[gi]), .lim(t_hi_lim[gi]), .need(need_t),
        .sticky(!sticky_mode_off), .read_clr(stat_clr), .flag(flags[4+2*gi])
      );
      amr_channel u_lo (
        .clock(clock), .rst(rst), .clr(sel_clr_t), .valid(result_valid[amr_pkg::NUM_IN+gi]),
        .result(t_lo_res[gi]), .lim(t_lo_lim[gi]), .need(need_t),
        .sticky(!sticky_mode_off), .read_clr(stat_clr), .flag(flags[5+2*gi])
      );
    end
  endgenerate

  // Die overtemperature with fixed hysteresis, single sample
  always_comb begin
    ot_lim = '{high: amr_pkg::OVERTEMP_LIM, low: 12'h000, hys: amr_pkg::OVERTEMP_HYS[6:0]};
  end
  amr_channel u_ot (
    .clock(clock), .rst(rst), .clr(clr_all), .valid(die_temp_valid),
    .result(die_temp), .lim(ot_lim), .need(9'h001),
    .sticky(!sticky_mode_off), .read_clr(stat_clr), .flag(flags[10])
  );

  // Global flag and open-drain drive
  always_comb begin
    enabled    = flags & source_irq_mask_bit;
    alarm_next = |enabled;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_reg        <= 11'h000;
      global_fault_flag <= 1'b0;
      die_overtemp_flag <= 1'b0;
      alarm_out         <= 1'b0;
      alarm_oe          <= 1'b0;
    end else begin
      status_reg        <= flags;
      global_fault_flag <= |flags;
      die_overtemp_flag <= flags[10];
      alarm_out         <= 1'b0;
      alarm_oe          <= alarm_next;
    end
  end

  AST_PIN_FOLLOWS: assert property (@(posedge clock) disable iff (rst)
    alarm_oe == $past(|(flags & source_irq_mask_bit))) else $error("alarm pin mismatch");
  AST_PIN_LOW: assert property (@(posedge clock) disable iff (rst)
    alarm_out == 1'b0) else $error("alarm drives high");
  AST_GLOBAL_OR: assert property (@(posedge clock) disable iff (rst)
    global_fault_flag == |status_reg) else $error("global flag not OR");
  AST_SW_BLOCK: assert property (@(posedge clock) disable iff (rst)
    $rose(host_busy_reg) |-> host_busy_reg [*8]) else $error("busy too short");
  AST_DEFAULT_SEL: assert property (@(posedge clock) disable iff (rst)
    defaults_reg |-> in_sel_reg == amr_pkg::IN_SEL_RST) else $error("sel not default");
  AST_TEMP_SEL: assert property (@(posedge clock) disable iff (rst)
    defaults_reg |-> temp_sel_reg == amr_pkg::TEMP_SEL_RST) else $error("tsel not default");
  AST_RESET_CLR: assert property (@(posedge clock) disable iff (rst)
    (defaults_reg && $past(defaults_reg)) |=> status_reg == 11'h000) else $error("status kept");
  AST_BAD_KEY: assert property (@(posedge clock) disable iff (rst)
    (sw_reset_wr && sw_reset_spi && sw_reset_data != amr_pkg::SPI_RST_KEY && !host_busy_reg
     && state_reg == amr_pkg::AMR_RUN) |=> !host_busy_reg) else $error("bad key reset");
endmodule

// File: verif/amr_host_model.sv
// Purpose: Host side model, pulls the alarm line up and issues status reads
// Assumes: Read requests arrive by nonblocking assignment on the falling edge
// Notes:   One read pulse follows each request cycle
`timescale 1ns/10ps
module amr_host_model (
  input  wire logic clock,
  input  wire logic alarm_out,
  input  wire logic alarm_oe,
  input  wire logic read_req,
  output logic      status_read,
  output logic      alarm_line
);
  // External pull-up sets the idle level whenever the pin is released
  assign alarm_line = alarm_oe ? alarm_out : 1'b1;
  // Read pulse launched off the falling edge
  initial status_read = 1'b0;
  always @(negedge clock) begin
    status_read <= read_req;
  end
endmodule

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the alarm monitor block
// Assumes: Limits high 800h, low 100h, hysteresis 10h on channels 0..6; die temp (7) uses fixed 096h/08h
// Notes:   Result word is {global flag, alarm line, status bits}
`timescale 1ns/10ps
module tb_top;
  logic                         clock, rst, reset_n_pin, die_temp_valid, read_req;
  logic                         input_sel_wr, temp_sel_wr, sticky_mode_off;
  logic                         sw_reset_wr, sw_reset_spi, status_read, alarm_line;
  logic [6:0]                   result_valid;
  logic [6:0][11:0]             result;
  logic [11:0]                  die_temp;
  amr_pkg::amr_limit_type [6:0] limits;
  logic [2:0]                   input_debounce_count_sel, in_sel_reg;
  logic [1:0]                   temp_debounce_count_sel, temp_sel_reg;
  logic [10:0]                  source_irq_mask_bit, status_reg;
  logic [15:0]                  sw_reset_data;
  logic                         global_fault_flag, die_overtemp_flag, alarm_out, alarm_oe;
  logic                         defaults_reg, host_busy_reg;
  int                           bad_count, comparisons, n;
  wire  [15:0]                  w = {3'h0, global_fault_flag, alarm_line, status_reg};

  amr_top u_dut (.clock(clock), .rst(rst), .reset_n_pin(reset_n_pin),
    .result_valid(result_valid), .result(result), .die_temp(die_temp),
    .die_temp_valid(die_temp_valid), .limits(limits),
    .input_debounce_count_sel(input_debounce_count_sel), .input_sel_wr(input_sel_wr),
    .temp_debounce_count_sel(temp_debounce_count_sel), .temp_sel_wr(temp_sel_wr),
    .source_irq_mask_bit(source_irq_mask_bit), .sticky_mode_off(sticky_mode_off),
    .status_read(status_read), .sw_reset_wr(sw_reset_wr), .sw_reset_spi(sw_reset_spi),
    .sw_reset_data(sw_reset_data), .status_reg(status_reg),
    .global_fault_flag(global_fault_flag), .die_overtemp_flag(die_overtemp_flag),
    .alarm_out(alarm_out), .alarm_oe(alarm_oe), .defaults_reg(defaults_reg),
    .host_busy_reg(host_busy_reg), .in_sel_reg(in_sel_reg), .temp_sel_reg(temp_sel_reg));
  amr_host_model u_host (.clock(clock), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
    .read_req(read_req), .status_read(status_read), .alarm_line(alarm_line));

  // Clock at 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Compare one value and count it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One result strobe, then wait for the status to settle
  task automatic strobe(input int ch, input logic [11:0] v);
    @(negedge clock);
    if (ch == 7) begin
      die_temp <= v;
      die_temp_valid <= 1'b1;
    end else begin
      result[ch] <= v;
      result_valid[ch] <= 1'b1;
    end
    @(negedge clock);
    die_temp_valid <= 1'b0;
    result_valid <= 7'h00;
    repeat (2) @(negedge clock);
  endtask
  // Status read through the host model
  task automatic rd;
    @(negedge clock);
    read_req <= 1'b1;
    @(negedge clock);
    read_req <= 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // Count select writes for both groups
  task automatic sel(input logic [2:0] i, input logic [1:0] t);
    @(negedge clock);
    input_debounce_count_sel <= i;
    temp_debounce_count_sel <= t;
    input_sel_wr <= 1'b1;
    temp_sel_wr <= 1'b1;
    @(negedge clock);
    input_sel_wr <= 1'b0;
    temp_sel_wr <= 1'b0;
    repeat (2) @(negedge clock);
  endtask
  // Software reset register write
  task automatic swr(input logic spi, input logic [15:0] d);
    @(negedge clock);
    sw_reset_wr <= 1'b1;
    sw_reset_spi <= spi;
    sw_reset_data <= d;
    @(negedge clock);
    sw_reset_wr <= 1'b0;
  endtask
  // Bounded wait on the busy flag, counting cycles spent
  task automatic wait_busy(input logic lvl);
    n = 0;
    while (host_busy_reg !== lvl && n < 1000) begin
      @(negedge clock);
      n++;
    end
    if (n == 1000) begin
      bad_count++;
      results();
    end
  endtask
  task automatic done_t(input string s);
    $display("test %0s done", s);
  endtask
  task automatic results;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    results();
  end
  // Main sequence
  initial begin
    {rst, reset_n_pin, die_temp_valid, read_req, input_sel_wr, temp_sel_wr} = 6'h30;
    {sticky_mode_off, sw_reset_wr, sw_reset_spi, result_valid} = 10'h000;
    {result, die_temp, sw_reset_data, input_debounce_count_sel} = '0;
    temp_debounce_count_sel = 2'h0;
    source_irq_mask_bit = 11'h7FD;
    for (int i = 0; i < 7; i++) limits[i] = '{12'h800, 12'h100, 7'h10};
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    chk({in_sel_reg, temp_sel_reg}, 16'h000E);
    chk(w, 16'h0800);
    sel(3'h0, 2'h1);
    chk({in_sel_reg, temp_sel_reg}, 16'h0001);
    strobe(1, 12'h0FF);
    chk(w, 16'h1802);
    strobe(1, 12'h110);
    rd;
    chk(w, 16'h0800);
    done_t("mask");
    strobe(0, 12'h801);
    chk(w, 16'h1001);
    strobe(0, 12'h7F1);
    rd;
    chk(w, 16'h1001);
    strobe(0, 12'h7F0);
    chk(w, 16'h1001);
    rd;
    chk(w, 16'h0800);
    done_t("sticky");
    sel(3'h1, 2'h1);
    repeat (3) strobe(2, 12'h900);
    strobe(2, 12'h400);
    repeat (3) strobe(2, 12'h900);
    chk(w, 16'h0800);
    strobe(2, 12'h900);
    chk(w, 16'h1004);
    strobe(2, 12'h400);
    rd;
    sel(3'h0, 2'h1);
    sticky_mode_off = 1'b1;
    strobe(3, 12'h900);
    chk(w, 16'h1008);
    strobe(3, 12'h7F0);
    chk(w, 16'h0800);
    sticky_mode_off = 1'b0;
    done_t("debounce");
    strobe(4, 12'h801);
    chk(w, 16'h0800);
    strobe(4, 12'h801);
    chk(w, 16'h1010);
    strobe(4, 12'h7F0);
    rd;
    chk(w, 16'h0800);
    strobe(7, 12'h096);
    chk(w, 16'h0800);
    strobe(7, 12'h097);
    chk({die_overtemp_flag, w[11:0]}, 16'h1400);
    strobe(7, 12'h08F);
    rd;
    chk(w, 16'h1400);
    strobe(7, 12'h08E);
    rd;
    chk(w, 16'h0800);
    done_t("temperature");
    strobe(0, 12'h801);
    swr(1'b1, 16'h1234);
    repeat (3) @(negedge clock);
    chk({host_busy_reg, w[11:0]}, 16'h0001);
    swr(1'b1, amr_pkg::SPI_RST_KEY);
    wait_busy(1'b1);
    // Status register shows the cleared flags one cycle after the reset edge
    @(negedge clock);
    chk({defaults_reg, w[11:0]}, 16'h1800);
    wait_busy(1'b0);
    chk(n, amr_pkg::SW_RST_CYC - 1);
    chk({in_sel_reg, temp_sel_reg}, 16'h000E);
    sel(3'h0, 2'h1);
    swr(1'b0, 16'h0000);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk({in_sel_reg, temp_sel_reg}, 16'h000E);
    done_t("software reset");
    // Host programs the count selects again after the reset
    sel(3'h2, 2'h3);
    repeat (7) begin
      strobe(3, 12'h900);
      strobe(5, 12'h0FF);
    end
    chk(w, 16'h0800);
    strobe(3, 12'h900);
    strobe(5, 12'h0FF);
    chk(w, 16'h1088);
    strobe(3, 12'h400);
    strobe(5, 12'h400);
    rd;
    chk(w, 16'h0800);
    done_t("count select");
    sel(3'h0, 2'h1);
    strobe(0, 12'h801);
    reset_n_pin = 1'b0;
    repeat (5) @(negedge clock);
    chk({defaults_reg, w[11:0]}, 16'h1800);
    chk({in_sel_reg, temp_sel_reg}, 16'h000E);
    reset_n_pin = 1'b1;
    repeat (5) @(negedge clock);
    chk(defaults_reg, 16'h0000);
    done_t("reset pin");
    results();
  end
endmodule
